/* tone_voice_pkg.sv */
package tone_voice_pkg;

	// Clock and decision timing
	localparam int CLK_HZ          = 20_000_000;
	localparam int CYC_PER_MS      = CLK_HZ / 1000;
	localparam int DECISION_MS     = 6;
	localparam int DECISION_CYCLES = DECISION_MS * CYC_PER_MS;
	localparam int INIT_MS         = 15;
	localparam int INIT_CYCLES     = INIT_MS * CYC_PER_MS;

	// Fast voice qualification, least time rounded up to whole decisions
	localparam int FAST_MS      = 90;
	localparam int FAST_SAMPLES = (FAST_MS + DECISION_MS - 1) / DECISION_MS;

	// Slow voice occupancy window, longest time rounded down
	localparam int WINDOW_MS      = 728;
	localparam int WINDOW_SAMPLES = WINDOW_MS / DECISION_MS;
	localparam int SLOW_SET_PCT   = 51;
	localparam int SLOW_CLR_PCT   = 10;
	localparam int PCT_FULL       = 100;

	// Level detector, level in dB re 775 mVrms, nominal -42 dB
	localparam int                  LEVEL_W         = 8;
	localparam logic signed [7:0]   LEVEL_THRESH_DB = 8'shd6;

	// Classification handed over by the signal analyser
	typedef enum logic [2:0] {
		CLS_NONE  = 3'h0,
		CLS_TONE  = 3'h1,
		CLS_DTMF  = 3'h2,
		CLS_VOICE = 3'h3,
		CLS_OOB   = 3'h4
	} class_t;

	typedef enum logic [2:0] {
		ST_OFF  = 3'h1,
		ST_INIT = 3'h2,
		ST_RUN  = 3'h4
	} state_t;

endpackage : tone_voice_pkg

/* tone_voice_output_logic.sv */
// Summary of operation
// - Fast voice rises about 90 ms after voice
// - Slow voice steadier, rises about 460 ms after voice, 370 ms after fast
// - Slow set when fast above 51% of 728 ms
// - Slow cleared below 10%, else holds
// - Level present when level above -42 dB
// - All three outputs gated by level present
// - Enable low resets, stops, clears outputs except ext_clock_sel, which follows the strap while off
// - Voice may rise while tone stays set
// - Class to tone/voice output encoding table
// - Tone accepted anywhere in 315 to 650 Hz
// - Outputs invalid during 15 ms initialisation
// - Fresh decision taken every 6 ms
`timescale 1ns/1ps

module tone_voice_output_logic #(
	parameter int DECISION_CYCLES = tone_voice_pkg::DECISION_CYCLES,
	parameter int INIT_CYCLES     = tone_voice_pkg::INIT_CYCLES,
	parameter int FAST_SAMPLES    = tone_voice_pkg::FAST_SAMPLES,
	parameter int WINDOW_SAMPLES  = tone_voice_pkg::WINDOW_SAMPLES
) (
	input  wire logic                                      ref_clk,
	input  wire logic                                      srst,
	input  wire logic                                      clk_en,
	input  wire logic                                      enable_pin,
	input  wire logic                                      clock_sel_pin,
	input  wire logic                                      xtal_in,
	input  wire logic signed [tone_voice_pkg::LEVEL_W-1:0] level_db,
	input  wire tone_voice_pkg::class_t                    class_code,
	output logic                                           tone_detect_out,
	output logic                                           voice_fast_out,
	output logic                                           voice_slow_out,
	output logic                                           tone_flag_out,
	output logic                                           crystal_drive_out,
	output logic                                           ext_clock_sel
);
	import tone_voice_pkg::*;

	localparam int DEC_W  = $clog2(DECISION_CYCLES + 1);
	localparam int INIT_W = $clog2(INIT_CYCLES + 1);
	localparam int RUN_W  = $clog2(FAST_SAMPLES + 1);
	localparam int WCNT_W = $clog2(WINDOW_SAMPLES + 1);

	// Pin synchronisers: enable, clock strap, crystal
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic [2:0] next_pin_s1;
	logic [2:0] next_pin_s2;
	logic       enable_s;
	logic       clock_sel_s;
	logic       xtal_s;

	always_comb begin
		next_pin_s1 = pin_s1;
		next_pin_s2 = pin_s2;
		if (clk_en) begin
			next_pin_s1 = {xtal_in, clock_sel_pin, enable_pin};
			next_pin_s2 = pin_s1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
		end else begin
			pin_s1 <= next_pin_s1;
			pin_s2 <= next_pin_s2;
		end
	end

	assign enable_s    = pin_s2[0];
	assign clock_sel_s = pin_s2[1];
	assign xtal_s      = pin_s2[2];

	// Power state and timers
	state_t            state;
	state_t            next_state;
	logic [INIT_W-1:0] init_cnt;
	logic [INIT_W-1:0] next_init_cnt;
	logic [DEC_W-1:0]  dec_cnt;
	logic [DEC_W-1:0]  next_dec_cnt;
	logic              next_ext_clock_sel;
	logic              tick;
	logic              run;

	assign run  = (state == ST_RUN);
	assign tick = run && (dec_cnt == DEC_W'(DECISION_CYCLES - 1));

	always_comb begin
		next_state         = state;
		next_init_cnt      = init_cnt;
		next_dec_cnt       = dec_cnt;
		next_ext_clock_sel = ext_clock_sel;
		if (clk_en) begin
			case (state)
				ST_OFF: begin
					// Strap is only looked at while the device is parked
					next_ext_clock_sel = clock_sel_s;
					next_init_cnt      = '0;
					next_dec_cnt       = '0;
					if (enable_s) begin
						next_state = ST_INIT;
					end
				end
				ST_INIT: begin
					next_init_cnt = init_cnt + INIT_W'(1);
					if (init_cnt == INIT_W'(INIT_CYCLES - 1)) begin
						next_state = ST_RUN;
					end
				end
				ST_RUN: begin
					if (tick) begin
						next_dec_cnt = '0;
					end else begin
						next_dec_cnt = dec_cnt + DEC_W'(1);
					end
				end
				default: begin
					next_state = ST_OFF;
				end
			endcase
			if (!enable_s) begin
				next_state = ST_OFF;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state         <= ST_OFF;
			init_cnt      <= '0;
			dec_cnt       <= '0;
			ext_clock_sel <= 1'b0;
		end else begin
			state         <= next_state;
			init_cnt      <= next_init_cnt;
			dec_cnt       <= next_dec_cnt;
			ext_clock_sel <= next_ext_clock_sel;
		end
	end

	// Detector flags, level gate and occupancy window
	logic                      level_ok;
	logic                      next_level_ok;
	logic                      next_tone_flag;
	logic                      fast_flag;
	logic                      next_fast_flag;
	logic                      slow_flag;
	logic                      next_slow_flag;
	logic [RUN_W-1:0]          voice_run;
	logic [RUN_W-1:0]          next_voice_run;
	logic [WINDOW_SAMPLES-1:0] win;
	logic [WINDOW_SAMPLES-1:0] next_win;
	logic [WCNT_W-1:0]         win_cnt;
	logic [WCNT_W-1:0]         next_win_cnt;
	logic [WCNT_W-1:0]         win_sum;
	logic                      win_hi;
	logic                      win_lo;
	logic                      is_voice;

	assign is_voice = (class_code == CLS_VOICE);
	// Count after this decision's shift, built from flops so no loop through next_ values
	assign win_sum  = win_cnt + WCNT_W'(fast_flag) - WCNT_W'(win[WINDOW_SAMPLES-1]);
	assign win_hi   = int'(win_sum) * PCT_FULL > SLOW_SET_PCT * WINDOW_SAMPLES;
	assign win_lo   = int'(win_sum) * PCT_FULL < SLOW_CLR_PCT * WINDOW_SAMPLES;

	always_comb begin
		next_level_ok  = level_ok;
		next_tone_flag = tone_flag_out;
		next_fast_flag = fast_flag;
		next_slow_flag = slow_flag;
		next_voice_run = voice_run;
		next_win       = win;
		next_win_cnt   = win_cnt;
		if (clk_en) begin
			next_level_ok = run && (level_db > LEVEL_THRESH_DB);
			if (!run) begin
				next_tone_flag = 1'b0;
				next_fast_flag = 1'b0;
				next_slow_flag = 1'b0;
				next_voice_run = '0;
				next_win       = '0;
				next_win_cnt   = '0;
			end else if (tick) begin
				// Analyser has already limited tones to 315..650 Hz
				case (class_code)
					CLS_TONE:  next_tone_flag = 1'b1;
					CLS_VOICE: next_tone_flag = tone_flag_out;
					default:   next_tone_flag = 1'b0;
				endcase
				if (!is_voice) begin
					next_voice_run = '0;
				end else if (voice_run != RUN_W'(FAST_SAMPLES)) begin
					next_voice_run = voice_run + RUN_W'(1);
				end
				next_fast_flag = (next_voice_run == RUN_W'(FAST_SAMPLES));
				next_win       = {win[WINDOW_SAMPLES-2:0], fast_flag};
				next_win_cnt   = win_sum;
				if (win_hi) begin
					next_slow_flag = 1'b1;
				end else if (win_lo) begin
					next_slow_flag = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			level_ok      <= 1'b0;
			tone_flag_out <= 1'b0;
			fast_flag     <= 1'b0;
			slow_flag     <= 1'b0;
			voice_run     <= '0;
			win           <= '0;
			win_cnt       <= '0;
		end else begin
			level_ok      <= next_level_ok;
			tone_flag_out <= next_tone_flag;
			fast_flag     <= next_fast_flag;
			slow_flag     <= next_slow_flag;
			voice_run     <= next_voice_run;
			win           <= next_win;
			win_cnt       <= next_win_cnt;
		end
	end

	// Gated pin outputs and oscillator drive
	logic next_tone_out;
	logic next_fast_out;
	logic next_slow_out;
	logic next_xtal_drive;

	always_comb begin
		next_tone_out   = tone_detect_out;
		next_fast_out   = voice_fast_out;
		next_slow_out   = voice_slow_out;
		next_xtal_drive = crystal_drive_out;
		if (clk_en) begin
			next_tone_out   = run && level_ok && tone_flag_out;
			next_fast_out   = run && level_ok && fast_flag;
			next_slow_out   = run && level_ok && slow_flag;
			// Crystal amplifier is powered down when off or on external clock
			next_xtal_drive = (state != ST_OFF) && !ext_clock_sel && !xtal_s;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tone_detect_out   <= 1'b0;
			voice_fast_out    <= 1'b0;
			voice_slow_out    <= 1'b0;
			crystal_drive_out <= 1'b0;
		end else begin
			tone_detect_out   <= next_tone_out;
			voice_fast_out    <= next_fast_out;
			voice_slow_out    <= next_slow_out;
			crystal_drive_out <= next_xtal_drive;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	a_off_outputs_low: assert property (clk_en && !enable_s |=> ##1
		!tone_detect_out && !voice_fast_out && !voice_slow_out)
		else $error("outputs not cleared while disabled");
	a_init_quiet: assert property (state == ST_INIT |=>
		!tone_detect_out && !voice_fast_out && !voice_slow_out)
		else $error("output asserted during initialisation");
	a_level_compare: assert property (clk_en && run |=>
		level_ok == ($past(level_db) > LEVEL_THRESH_DB))
		else $error("level detector disagrees with threshold");
	a_level_gate: assert property (clk_en && !level_ok |=>
		!tone_detect_out && !voice_fast_out && !voice_slow_out)
		else $error("output asserted below level threshold");
	a_tick_spacing: assert property (clk_en && tick |=> !tick && dec_cnt == '0)
		else $error("decision tick spacing wrong");
	a_fast_rise: assert property ($rose(fast_flag) |->
		voice_run == RUN_W'(FAST_SAMPLES) && $past(is_voice))
		else $error("fast voice rose without full voice run");
	a_slow_set: assert property (clk_en && tick && win_hi |=> slow_flag)
		else $error("slow voice not set above upper occupancy");
	a_slow_clear: assert property (clk_en && tick && win_lo |=> !slow_flag)
		else $error("slow voice not cleared below lower occupancy");
	a_slow_hold: assert property (clk_en && tick && !win_hi && !win_lo
		|=> $stable(slow_flag))
		else $error("slow voice changed between thresholds");
	a_tone_keep: assert property (clk_en && tick && is_voice && tone_flag_out
		|=> tone_flag_out)
		else $error("tone flag dropped by voice decision");
	a_tone_encode: assert property (clk_en && tick && class_code != CLS_TONE
		&& !is_voice |=> !tone_flag_out)
		else $error("tone flag set by non-tone class");
	a_xtal_ext: assert property (ext_clock_sel |=> !crystal_drive_out)
		else $error("crystal driven with external clock strap");

	c_tone_out: cover property ($rose(tone_detect_out));
	c_both_out: cover property (tone_detect_out && voice_fast_out);
	c_slow_out: cover property ($rose(voice_slow_out));
	c_slow_drop: cover property ($fell(voice_slow_out) && enable_s);

endmodule : tone_voice_output_logic

/* host_cadence_model.sv */
`timescale 1ns/1ps

module host_cadence_model #(
	parameter int SETTLE  = 10,
	parameter int CONFIRM = 16
) (
	input  wire logic ref_clk,
	input  wire logic enable_pin,
	input  wire logic tone_detect_out,
	input  wire logic voice_fast_out,
	input  wire logic voice_slow_out,
	output logic      settled,
	output int        tone_len,
	output logic      voice_sure
);
	int wait_cnt = 0;
	int slow_cnt = 0;
	int tone_run = 0;

	always @(posedge ref_clk) begin
		wait_cnt <= enable_pin ? wait_cnt + int'(wait_cnt < SETTLE) : 0;
		tone_run <= tone_detect_out ? tone_run + 1 : 0;
		slow_cnt <= voice_slow_out ? slow_cnt + int'(slow_cnt < CONFIRM) : 0;
	end
	// Outputs trusted only once the start-up wait has run out
	assign settled    = wait_cnt == SETTLE;
	assign tone_len   = tone_run;
	assign voice_sure = voice_fast_out && slow_cnt == CONFIRM;
endmodule : host_cadence_model

/* test_tone_voice_output_logic.sv */
`timescale 1ns/1ps

module test_tone_voice_output_logic;
	import tone_voice_pkg::*;
	localparam int DC = 8;
	localparam int FS = 3;
	localparam int WS = 10;
	logic                      ref_clk = 0;
	logic                      srst = 1;
	logic                      clk_en = 1;
	logic                      enable_pin = 0;
	logic                      clock_sel_pin = 0;
	logic                      xtal_in = 0;
	logic signed [LEVEL_W-1:0] level_db = 8'sh00;
	class_t                    class_code = CLS_NONE;
	logic                      tone_detect_out, voice_fast_out, voice_slow_out;
	logic                      tone_flag_out, crystal_drive_out, ext_clock_sel;
	logic                      settled, voice_sure;
	int                        tone_len, m_tone, m_run, m_fast, m_slow, m_cnt, lvl_ok;
	int                        error_cnt = 0;
	int                        comparisons = 0;
	int                        cyc = 0;
	int                        seed = 32'h857681c9;
	int                        win[$];

	tone_voice_output_logic #(.DECISION_CYCLES(DC), .INIT_CYCLES(10), .FAST_SAMPLES(FS),
		.WINDOW_SAMPLES(WS)) u_dut (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
		.enable_pin(enable_pin), .clock_sel_pin(clock_sel_pin), .xtal_in(xtal_in),
		.level_db(level_db), .class_code(class_code), .tone_detect_out(tone_detect_out),
		.voice_fast_out(voice_fast_out), .voice_slow_out(voice_slow_out),
		.tone_flag_out(tone_flag_out), .crystal_drive_out(crystal_drive_out),
		.ext_clock_sel(ext_clock_sel));
	host_cadence_model u_host (.ref_clk(ref_clk), .enable_pin(enable_pin),
		.tone_detect_out(tone_detect_out), .voice_fast_out(voice_fast_out),
		.voice_slow_out(voice_slow_out), .settled(settled), .tone_len(tone_len),
		.voice_sure(voice_sure));

	initial forever #25 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			error_cnt++;
			conclude();
		end
	end

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	task automatic check(string what, logic got, logic exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: %s is %b", $time, what, got);
		end
	endtask : check

	task automatic model_reset();
		m_tone = 0;
		m_run = 0;
		m_fast = 0;
		m_slow = 0;
		win = {};
		repeat (WS) win.push_back(0);
	endtask : model_reset

	// One decision of the reference model, window takes the fast flag held before it
	task automatic step(class_t c);
		win.push_back(m_fast);
		void'(win.pop_front());
		m_cnt = win.sum();
		if (m_cnt * 100 > SLOW_SET_PCT * WS) m_slow = 1;
		else if (m_cnt * 100 < SLOW_CLR_PCT * WS) m_slow = 0;
		m_tone = int'(c == CLS_TONE || (c == CLS_VOICE && m_tone != 0));
		m_run = (c == CLS_VOICE) ? m_run + 1 : 0;
		m_fast = int'(m_run >= FS);
	endtask : step

	// Class changes midway between ticks, so exactly one tick sees it
	task automatic decide(class_t c, int lvl);
		@(posedge ref_clk);
		class_code <= c;
		level_db <= lvl[7:0];
		repeat (DC - 1) @(posedge ref_clk);
		#1;
		step(c);
		lvl_ok = int'(lvl > -42);
		check("tone", tone_detect_out, m_tone != 0 && lvl_ok != 0);
		check("fast", voice_fast_out, m_fast != 0 && lvl_ok != 0);
		check("slow", voice_slow_out, m_slow != 0 && lvl_ok != 0);
		check("raw tone", tone_flag_out, m_tone != 0);
	endtask : decide

	// Enable and lock onto the decision tick by the first tone decision
	task automatic power_up();
		@(posedge ref_clk);
		class_code <= CLS_TONE;
		level_db <= 8'sh00;
		enable_pin <= 1;
		model_reset();
		for (int i = 0; i < 100 && tone_flag_out !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
			if (tone_flag_out !== 1'b1)
				check("idle", tone_detect_out | voice_fast_out | voice_slow_out, 0);
		end
		check("host wait", settled, 1);
		step(CLS_TONE);
		repeat (2) @(posedge ref_clk);
	endtask : power_up

	initial begin
		model_reset();
		repeat (10) @(posedge ref_clk);
		srst <= 0;
		power_up();
		check("strap", ext_clock_sel, 0);
		for (int c = 0; c < 5; c++) decide(class_t'(c), 0);
		$display("test classes done");
		decide(CLS_TONE, 0);
		repeat (FS + WS) decide(CLS_VOICE, 0);
		check("host tone", tone_len >= (FS + WS) * DC, 1);
		check("host voice", voice_sure, 1);
		decide(CLS_VOICE, -42);
		decide(CLS_VOICE, -41);
		repeat (WS + 1) decide(CLS_NONE, 0);
		$display("test voice done");
		@(posedge ref_clk);
		xtal_in <= 1;
		repeat (3) @(posedge ref_clk);
		#1 check("xtal hi", crystal_drive_out, 0);
		@(posedge ref_clk);
		xtal_in <= 0;
		repeat (3) @(posedge ref_clk);
		#1 check("xtal lo", crystal_drive_out, 1);
		repeat (150) decide((($random(seed) & 1) != 0) ? CLS_VOICE : class_t'($unsigned($random(seed)) % 5),
			-50 + int'($unsigned($random(seed)) % 20));
		$display("test random done");
		@(posedge ref_clk);
		clk_en <= 0;
		xtal_in <= 1;
		repeat (8) @(posedge ref_clk);
		#1 check("frozen", crystal_drive_out, 1);
		@(posedge ref_clk);
		clk_en <= 1;
		xtal_in <= 0;
		$display("test freeze done");
		@(posedge ref_clk);
		enable_pin <= 0;
		clock_sel_pin <= 1;
		repeat (8) @(posedge ref_clk);
		#1 check("off", tone_detect_out | voice_fast_out | voice_slow_out | crystal_drive_out, 0);
		power_up();
		check("strap", ext_clock_sel, 1);
		check("xtal off", crystal_drive_out, 0);
		repeat (FS + 1) decide(CLS_VOICE, 0);
		$display("test enable done");
		conclude();
	end
endmodule : test_tone_voice_output_logic
